// *** rtl/atpc_correction_core.sv ***
// converter result correction with power-up coefficient load from flash spare pages
`timescale 1ns/1ns
`default_nettype none
module atpc_correction_core
  import atpc_pkg::*;
#(
  parameter bit INCLUDE_CORRECTION = 1'b1
) (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic [REG_ADDR_W-1:0]   regAddr,
  input  wire logic [31:0]             regWrData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRdData,
  output logic                         flashRd,
  output logic      [FLASH_ADDR_W-1:0] flashAddr,
  input  wire logic [31:0]             flashRdData,
  output logic                         lookupRegionWriteEnable,
  output logic                         coefficientRegionWriteEnable,
  input  wire logic                    resultValid,
  input  wire logic [RES_W-1:0]        resultRaw,
  input  wire logic [CH_W-1:0]         resultChannel,
  input  wire logic [PRE_W-1:0]        resultPrescaler,
  input  wire logic                    resultSaturated,
  output logic                         outValid,
  output logic      [RES_W-1:0]        outResult,
  output logic      [CH_W-1:0]         outChannel,
  output logic      [PRE_W-1:0]        outPrescaler,
  output logic                         outSaturated,
  output logic                         outCorrected,
  output logic                         initDone
);
  localparam int TAG_W = CH_W + PRE_W + 1;

  atpc_init_state_t  state_ff;
  logic [7:0]        idx_ff;
  logic              flashRd_ff;
  logic [FLASH_ADDR_W-1:0] flashAddr_ff;
  logic              lutWen_ff;
  logic              coefWen_ff;
  logic [7:0]        wrIdx_ff;
  logic              initDone_ff;
  logic              ctrlRef_ff;
  logic              ctrlBypass_ff;
  logic [31:0]       regRdData_ff;
  logic [15:0]       corrCount_ff;
  logic [7:0]        lutRd;
  logic [31:0]       coefRd;
  logic              stgValid_ff;
  logic              stgEligible_ff;
  logic [RES_W-1:0]  stgRaw_ff;
  logic [PRE_W-1:0]  stgPre_ff;
  logic [TAG_W-1:0]  stgTag_ff;
  logic              pipeApply;
  logic [TAG_W-1:0]  pipeTag;

  // ---------------- power-up load: lookup words, then coefficient words
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= INIT_LUT;
      idx_ff   <= 8'h00;
    end else begin
      case (state_ff)
        INIT_LUT: begin
          if (idx_ff == LUT_WORDS - 8'h01) begin
            state_ff <= INIT_COEF;
            idx_ff   <= 8'h00;
          end else begin
            idx_ff <= idx_ff + 8'h01;
          end
        end
        INIT_COEF: begin
          if (idx_ff == COEF_WORDS - 8'h01) begin
            state_ff <= INIT_DRAIN;
          end else begin
            idx_ff <= idx_ff + 8'h01;
          end
        end
        INIT_DRAIN: state_ff <= INIT_DONE;
        INIT_DONE:  state_ff <= INIT_DONE;
        default:    state_ff <= INIT_LUT;
      endcase
    end
  end

  // read address: one word per cycle from the spare page of the partition sector
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flashRd_ff   <= 1'b0;
      flashAddr_ff <= '0;
    end else begin
      flashRd_ff <= (state_ff == INIT_LUT) || (state_ff == INIT_COEF); // see R5
      if (state_ff == INIT_LUT) begin
        flashAddr_ff <= spareAddr(LUT_FIRST_PAGE, idx_ff[WORD_W-1:0]); // see R10
      end else if (state_ff == INIT_COEF) begin
        flashAddr_ff <= spareAddr(COEF_FIRST_PAGE + {3'h0, idx_ff[7:5]},
                                  idx_ff[WORD_W-1:0]); // see R3
      end
    end
  end

  // flash answers one cycle after the read; the enable marks that data cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lutWen_ff  <= 1'b0;
      coefWen_ff <= 1'b0;
      wrIdx_ff   <= 8'h00;
    end else begin
      lutWen_ff  <= flashRd_ff && (state_ff == INIT_LUT || flashAddr_ff[17:12] == LUT_FIRST_PAGE)
                    && flashAddr_ff[17:12] == LUT_FIRST_PAGE; // see R8
      coefWen_ff <= flashRd_ff && flashAddr_ff[17:12] >= COEF_FIRST_PAGE; // see R9
      wrIdx_ff   <= {flashAddr_ff[14:12] - COEF_FIRST_PAGE[2:0], flashAddr_ff[6:2]}; // see R12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      initDone_ff <= 1'b0;
    end else begin
      initDone_ff <= (state_ff == INIT_DONE);
    end
  end

  assign flashRd                      = flashRd_ff;
  assign flashAddr                    = flashAddr_ff;
  assign lookupRegionWriteEnable      = lutWen_ff;
  assign coefficientRegionWriteEnable = coefWen_ff;
  assign initDone                     = initDone_ff;

  // one lookup byte per channel, one bit per prescaler level
  atpc_coef_ram #(.DEPTH(32), .WIDTH(8), .ADDR_W(CH_W)) u_lut_ram (
    .sys_clk (sys_clk),
    .wrEn    (lutWen_ff),
    .wrAddr  (wrIdx_ff[CH_W-1:0]),
    .wrData  (flashRdData[7:0]),
    .rdAddr  (resultChannel), // see R18
    .rdData  (lutRd)
  );

  // gain in high half, signed offset in low half, indexed {channel, prescaler}
  atpc_coef_ram #(.DEPTH(256), .WIDTH(32), .ADDR_W(CH_W + PRE_W)) u_coef_ram (
    .sys_clk (sys_clk),
    .wrEn    (coefWen_ff),
    .wrAddr  (wrIdx_ff),
    .wrData  (flashRdData),
    .rdAddr  ({resultChannel, resultPrescaler}), // see R1
    .rdData  (coefRd)
  );

  // ---------------- register port
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrlRef_ff    <= CTRL_RESET[CTRL_REF_BIT];
      ctrlBypass_ff <= CTRL_RESET[CTRL_BYPASS_BIT];
    end else if (regWr && regAddr == CTRL_OFS) begin
      ctrlRef_ff    <= regWrData[CTRL_REF_BIT];
      ctrlBypass_ff <= regWrData[CTRL_BYPASS_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRdData_ff <= 32'h0000_0000;
    end else if (regRd && regAddr == CTRL_OFS) begin
      regRdData_ff <= {30'h0, ctrlBypass_ff, ctrlRef_ff};
    end else if (regRd && regAddr == STATUS_OFS) begin
      regRdData_ff <= {corrCount_ff, 14'h0, flashRd_ff, initDone_ff};
    end else begin
      regRdData_ff <= 32'h0000_0000;
    end
  end

  assign regRdData = regRdData_ff;

  // wraps; software reads differences only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      corrCount_ff <= 16'h0000;
    end else if (outValid && outCorrected) begin
      corrCount_ff <= corrCount_ff + 16'h0001;
    end
  end

  // ---------------- result stream: raw tag only, no sequencer state, so any system
  // configuration feeds it alike (see R7)
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stgValid_ff <= 1'b0;
    end else begin
      stgValid_ff <= resultValid;
    end
  end

  // decision sampled with the result so a mid-flight control write cannot split it
  always_ff @(posedge sys_clk) begin
    stgEligible_ff <= initDone_ff && ctrlRef_ff // see R2
                      && (resultChannel < CH_W'(NUM_CHANNELS))
                      && !(resultSaturated && ctrlBypass_ff); // see R13
    stgRaw_ff      <= resultRaw;
    stgPre_ff      <= resultPrescaler;
    stgTag_ff      <= {resultChannel, resultPrescaler, resultSaturated};
  end

  assign pipeApply = stgEligible_ff && lutRd[stgPre_ff]; // see R18

  if (INCLUDE_CORRECTION) begin : g_core
    atpc_compute_pipe #(.LAT(CAL_LATENCY - 1), .TAG_W(TAG_W)) u_pipe (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .inValid    (stgValid_ff),
      .inRaw      (stgRaw_ff),
      .inGain     (coefRd[31:16]),
      .inOffset   (coefRd[15:0]),
      .inApply    (pipeApply), // see R6
      .inTag      (stgTag_ff),
      .outValid   (outValid),
      .outResult  (outResult),
      .outApplied (outCorrected),
      .outTag     (pipeTag)
    );
  end else begin : g_nocore
    // core left out at build time: results pass with one register stage
    logic             bypValid_ff;
    logic [RES_W-1:0] bypResult_ff;
    logic [TAG_W-1:0] bypTag_ff;
    always_ff @(posedge sys_clk) begin
      bypValid_ff  <= srst ? 1'b0 : resultValid; // see R15
      bypResult_ff <= resultRaw;
      bypTag_ff    <= {resultChannel, resultPrescaler, resultSaturated};
    end
    assign outValid     = bypValid_ff;
    assign outResult    = bypResult_ff;
    assign outCorrected = 1'b0;
    assign pipeTag      = bypTag_ff;
  end

  assign outChannel   = pipeTag[TAG_W-1:PRE_W+1];
  assign outPrescaler = pipeTag[PRE_W:1];
  assign outSaturated = pipeTag[0];

  // ---------------- checks
  sequence s_flash_read(logic [5:0] lo, logic [5:0] hi);
    flashRd && inSpareRange(flashAddr, lo, hi);
  endsequence

  // each load read is answered by exactly one region enable in the next cycle
  sequence s_data_cycle;
    ##1 (lutWen_ff ^ coefWen_ff);
  endsequence

  a_fixed_latency: assert property (@(posedge sys_clk) disable iff (srst) // see R16
    INCLUDE_CORRECTION && resultValid |-> ##14 outValid)
    else $error("corrected result not out 14 cycles after raw result");

  a_ref_gate: assert property (@(posedge sys_clk) disable iff (srst) // see R2
    resultValid && !ctrlRef_ff |-> ##14 !outCorrected && outResult == $past(resultRaw, 14))
    else $error("correction applied with reference other than 2.56 V");

  a_sat_bypass: assert property (@(posedge sys_clk) disable iff (srst) // see R13
    resultValid && resultSaturated && ctrlBypass_ff |=> !pipeApply)
    else $error("saturated result corrected while bypass is set");

  a_lut_window: assert property (@(posedge sys_clk) disable iff (srst) // see R10
    flashRd && state_ff == INIT_COEF && idx_ff == 8'h00
    |-> s_flash_read(LUT_FIRST_PAGE, LUT_LAST_PAGE))
    else $error("lookup read outside its spare pages");

  a_coef_window: assert property (@(posedge sys_clk) disable iff (srst) // see R3
    lutWen_ff || coefWen_ff |-> $past(flashRd) && (lutWen_ff ?
      inSpareRange($past(flashAddr), LUT_FIRST_PAGE, LUT_LAST_PAGE) :
      inSpareRange($past(flashAddr), COEF_FIRST_PAGE, COEF_LAST_PAGE)))
    else $error("write enable without a matching partition read");

  a_wen_exclusive: assert property (@(posedge sys_clk) disable iff (srst) // see R9
    flashRd |-> s_data_cycle)
    else $error("both region write enables high together");

  a_thresh_untouched: assert property (@(posedge sys_clk) disable iff (srst) // see R11
    flashRd |-> flashAddr[18] || flashAddr[17:0] < THRESH_FIRST_ADDR
                || flashAddr[17:0] > THRESH_LAST_ADDR)
    else $error("load touched the threshold configuration sector");

  a_load_time: assert property (@(posedge sys_clk) // see R5
    $fell(srst) |-> ##[270:280] initDone)
    else $error("coefficient load did not finish in time");

  a_stream_order: assert property (@(posedge sys_clk) disable iff (srst) // see R18
    resultValid |-> ##14 outChannel == $past(resultChannel, 14)
                      && outPrescaler == $past(resultPrescaler, 14))
    else $error("channel tag lost alignment with its result");
endmodule
`default_nettype wire

// *** rtl/atpc_pkg.sv ***
// constants, types and helpers shared by the two-point converter correction block
// Behaviour
// R1 - keep separate gain and offset per prescaler level for all thirty channels
// R2 - correction applies only while the converter reference is configured as 2.56 V
// R3 - coefficient partition sits in spare pages 50..62 of flash block 0
// R4 - uncalibrated parts get gain 1 and offset 0 prefilled by others
// R5 - after power-up reset an init machine copies coefficients from flash into SRAM
// R6 - corrected value gain*raw+offset replaces raw value in the result stream
// R7 - insertion behaves the same in full, sequence-only and converter-only systems
// R8 - active-high write enable gates lookup-table region writes
// R9 - second active-high write enable gates coefficient region writes
// R10 - lookup partition in spare pages 43..48 marks which combinations get corrected
// R11 - threshold configuration lives in sector 63, 0x3F000..0x3FF80, up to 32 pages
// R12 - flash block has 64 sectors of 32 pages plus one spare page
// R13 - saturation bypass option forwards saturated results uncorrected, else corrects them
// R14 - simulation flash image holds gain 1.0 and offset 0 everywhere; dv image: channel 0 only, else gain 1.5, offset +16/-8
// R15 - correction included by default, build option removes the core
// R16 - correction path adds a fixed fourteen-cycle latency
// R17 - input is measured value, output is actual value, gain slope, offset constant
// R18 - coefficient pair and lookup bit are selected by channel and prescaler
package atpc_pkg;
  localparam int NUM_CHANNELS    = 30;
  localparam int PRESCALE_LEVELS = 8;
  localparam int CH_W            = 5;
  localparam int PRE_W           = 3;
  localparam int RES_W           = 12;
  localparam int GAIN_W          = 16;
  localparam int OFFS_W          = 16;
  localparam int GAIN_FRAC       = 14;
  localparam int CAL_LATENCY     = 14;
  localparam logic [GAIN_W-1:0] UNITY_GAIN  = 16'h4000;
  localparam logic [OFFS_W-1:0] ZERO_OFFSET = 16'h0000;

  // flash geometry: {spare, sector, page, word, byte}
  localparam int FLASH_ADDR_W     = 19;
  localparam int FLASH_SECTORS    = 64;
  localparam int PAGES_PER_SECTOR = 32;
  localparam int WORDS_PER_PAGE   = 32;
  localparam int SEC_W            = 6;
  localparam int WORD_W           = 5;
  localparam logic [5:0] COEF_FIRST_PAGE = 6'h32;
  localparam logic [5:0] COEF_LAST_PAGE  = 6'h3E;
  localparam logic [5:0] LUT_FIRST_PAGE  = 6'h2B;
  localparam logic [5:0] LUT_LAST_PAGE   = 6'h30;
  localparam logic [17:0] THRESH_FIRST_ADDR = 18'h3F000;
  localparam logic [17:0] THRESH_LAST_ADDR  = 18'h3FF80;
  localparam int THRESH_MAX_PAGES = 32;
  localparam logic [7:0] LUT_WORDS  = 8'h1E;
  localparam logic [7:0] COEF_WORDS = 8'hF0;

  // register port
  localparam int REG_ADDR_W = 8;
  localparam logic [REG_ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [REG_ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam int CTRL_REF_BIT    = 0;
  localparam int CTRL_BYPASS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  typedef enum logic [1:0] {INIT_LUT, INIT_COEF, INIT_DRAIN, INIT_DONE} atpc_init_state_t;

  // byte address of a word in the spare page of one sector
  function automatic logic [FLASH_ADDR_W-1:0] spareAddr(input logic [SEC_W-1:0] sector,
                                                       input logic [WORD_W-1:0] word);
    spareAddr = {1'b1, sector, 5'h00, word, 2'h0};
  endfunction

  function automatic logic inSpareRange(input logic [FLASH_ADDR_W-1:0] a,
                                        input logic [5:0] lo, input logic [5:0] hi);
    inSpareRange = a[18] && (a[17:12] >= lo) && (a[17:12] <= hi);
  endfunction
endpackage

// *** rtl/atpc_coef_ram.sv ***
// single-port-write, registered-read SRAM for correction tables
`timescale 1ns/1ns
`default_nettype none
module atpc_coef_ram #(
  parameter int DEPTH  = 256,
  parameter int WIDTH  = 32,
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]  wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [WIDTH-1:0]  rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // no reset on contents; read before the load finishes is masked upstream
  always_ff @(posedge sys_clk) begin
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// *** rtl/atpc_compute_pipe.sv ***
// multiply-add-clamp pipeline with fixed latency for the correction path
`timescale 1ns/1ns
`default_nettype none
module atpc_compute_pipe
  import atpc_pkg::*;
#(
  parameter int LAT   = CAL_LATENCY - 1,
  parameter int TAG_W = 9
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              inValid,
  input  wire logic [RES_W-1:0]  inRaw,
  input  wire logic [GAIN_W-1:0] inGain,
  input  wire logic [OFFS_W-1:0] inOffset,
  input  wire logic              inApply,
  input  wire logic [TAG_W-1:0]  inTag,
  output logic                   outValid,
  output logic      [RES_W-1:0]  outResult,
  output logic                   outApplied,
  output logic      [TAG_W-1:0]  outTag
);
  localparam int DLY      = LAT - 2;
  localparam int SCALED_W = RES_W + GAIN_W - GAIN_FRAC;
  localparam int SUM_W    = OFFS_W + 2;
  localparam logic signed [SUM_W-1:0] RES_MAX = SUM_W'((1 << RES_W) - 1);

  logic [RES_W+GAIN_W-1:0] prod_ff;
  logic [OFFS_W-1:0]       offs_ff;
  logic [RES_W-1:0]        raw1_ff;
  logic                    apply1_ff;
  logic                    valid1_ff;
  logic [TAG_W-1:0]        tag1_ff;
  logic signed [SUM_W-1:0] sum;
  logic [RES_W-1:0]        nxt_result;
  logic                    chValid_ff [DLY+1];
  logic [RES_W-1:0]        chResult_ff [DLY+1];
  logic                    chApplied_ff [DLY+1];
  logic [TAG_W-1:0]        chTag_ff [DLY+1];

  always_ff @(posedge sys_clk) begin
    valid1_ff <= srst ? 1'b0 : inValid;
  end

  // measured value times slope correction
  always_ff @(posedge sys_clk) begin
    prod_ff   <= inRaw * inGain; // see R17
    offs_ff   <= inOffset;
    raw1_ff   <= inRaw;
    apply1_ff <= inApply;
    tag1_ff   <= inTag;
  end

  // add constant correction, clamp to converter range
  always_comb begin
    sum = $signed({{(SUM_W-SCALED_W){1'b0}}, prod_ff[RES_W+GAIN_W-1:GAIN_FRAC]})
        + $signed({{(SUM_W-OFFS_W){offs_ff[OFFS_W-1]}}, offs_ff}); // see R6
    if (!apply1_ff) begin
      nxt_result = raw1_ff;
    end else if (sum < 0) begin
      nxt_result = '0;
    end else if (sum > RES_MAX) begin
      nxt_result = RES_MAX[RES_W-1:0];
    end else begin
      nxt_result = sum[RES_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    chValid_ff[0]   <= srst ? 1'b0 : valid1_ff;
    chResult_ff[0]  <= nxt_result;
    chApplied_ff[0] <= apply1_ff;
    chTag_ff[0]     <= tag1_ff;
  end

  // padding stages keep the total latency fixed regardless of arithmetic depth
  for (genvar k = 1; k <= DLY; k++) begin : g_dly
    always_ff @(posedge sys_clk) begin
      chValid_ff[k]   <= srst ? 1'b0 : chValid_ff[k-1]; // see R16
      chResult_ff[k]  <= chResult_ff[k-1];
      chApplied_ff[k] <= chApplied_ff[k-1];
      chTag_ff[k]     <= chTag_ff[k-1];
    end
  end

  assign outValid   = chValid_ff[DLY];
  assign outResult  = chResult_ff[DLY];
  assign outApplied = chApplied_ff[DLY];
  assign outTag     = chTag_ff[DLY];

  a_unity_passthru: assert property (@(posedge sys_clk) disable iff (srst) // see R4
    inValid && inApply && inGain == UNITY_GAIN && inOffset == ZERO_OFFSET
    |-> ##13 outValid && outResult == $past(inRaw, 13))
    else $error("unity gain with zero offset altered the result");
endmodule
`default_nettype wire

// *** dv/atpc_flash_model.sv ***
// flash spare-page image answering the power-up coefficient load
`timescale 1ns/1ns
`default_nettype none
module atpc_flash_model
  import atpc_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    flashRd,
  input  wire logic [FLASH_ADDR_W-1:0] flashAddr,
  output logic      [31:0]             flashRdData
);
  logic [5:0] sec;
  logic [4:0] word;
  logic [7:0] idx;
  assign sec  = flashAddr[17:12];
  assign word = flashAddr[6:2];
  assign idx  = {sec[2:0] - 3'h2, word};
  initial flashRdData = 32'h0;
  // idle bus shows the inverted last word, so a late sample is caught
  always @(posedge sys_clk) begin
    if (flashRd !== 1'b1) begin
      flashRdData <= ~flashRdData;
    end else if (sec == LUT_FIRST_PAGE) begin
      flashRdData <= {24'h0, (word == 5'h03) ? 8'h00 : 8'hFF};
    end else if (idx[7:3] == 5'h00) begin
      flashRdData <= {UNITY_GAIN, ZERO_OFFSET};
    end else begin
      flashRdData <= {16'h6000, idx[3] ? 16'hFFF8 : 16'h0010};
    end
  end
endmodule
`default_nettype wire

// *** dv/test_adc_two_point_calibration.sv ***
// self-checking bench for the converter correction core
`timescale 1ns/1ns
`default_nettype none
module test_adc_two_point_calibration
  import atpc_pkg::*;
;
  logic                    sys_clk = 1'b0;
  logic                    srst = 1'b1;
  logic [REG_ADDR_W-1:0]   regAddr = 8'h00;
  logic [31:0]             regWrData = 32'h0;
  logic                    regWr = 1'b0;
  logic                    regRd = 1'b0;
  logic [31:0]             regRdData;
  logic                    flashRd;
  logic [FLASH_ADDR_W-1:0] flashAddr;
  logic [31:0]             flashRdData;
  logic                    lutWe;
  logic                    coefWe;
  logic                    resultValid = 1'b0;
  logic [RES_W-1:0]        resultRaw = 12'h000;
  logic [CH_W-1:0]         resultChannel = 5'h00;
  logic [PRE_W-1:0]        resultPrescaler = 3'h0;
  logic                    resultSaturated = 1'b0;
  logic                    outValid;
  logic [RES_W-1:0]        outResult;
  logic [CH_W-1:0]         outChannel;
  logic [PRE_W-1:0]        outPrescaler;
  logic                    outSaturated;
  logic                    outCorrected;
  logic                    initDone;
  int                      err_count = 0;
  int                      checks = 0;
  int                      lutCnt = 0;
  int                      coefCnt = 0;
  int                      addrBad = 0;

  initial forever #20 sys_clk = ~sys_clk;

  atpc_correction_core uut (
    .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .flashRd(flashRd),
    .flashAddr(flashAddr), .flashRdData(flashRdData),
    .lookupRegionWriteEnable(lutWe), .coefficientRegionWriteEnable(coefWe),
    .resultValid(resultValid), .resultRaw(resultRaw), .resultChannel(resultChannel),
    .resultPrescaler(resultPrescaler), .resultSaturated(resultSaturated),
    .outValid(outValid), .outResult(outResult), .outChannel(outChannel),
    .outPrescaler(outPrescaler), .outSaturated(outSaturated),
    .outCorrected(outCorrected), .initDone(initDone)
  );

  atpc_flash_model flash (
    .sys_clk(sys_clk), .flashRd(flashRd), .flashAddr(flashAddr), .flashRdData(flashRdData)
  );

  // load traffic watch: enables counted, overlaps and reads outside lookup page 43 and coefficient pages 50..62 flagged
  always @(posedge sys_clk) begin
    if (lutWe === 1'b1) lutCnt++;
    if (coefWe === 1'b1) coefCnt++;
    if (lutWe === 1'b1 && coefWe === 1'b1) addrBad++;
    if (flashRd === 1'b1 && !(flashAddr[18] === 1'b1 && (flashAddr[17:12] === LUT_FIRST_PAGE
        || (flashAddr[17:12] >= COEF_FIRST_PAGE && flashAddr[17:12] <= COEF_LAST_PAGE))))
      addrBad++;
  end

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic regCheck(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData === e, "register read");
  endtask

  // model of gain 1.5 with offset +16 or -8, channel 0 passed unchanged, clamped to the result range
  function automatic logic [11:0] expOf(input logic [11:0] raw, input logic [4:0] ch);
    int v;
    v = ((int'(raw) * 24576) >>> 14) + (ch[0] ? -8 : 16);
    if (ch == 5'h00) v = int'(raw);
    expOf = (v < 0) ? 12'h000 : (v > 4095) ? 12'hFFF : 12'(v);
  endfunction

  task automatic send(input logic [11:0] raw, input logic [4:0] ch, input logic [2:0] pre,
                      input logic sat, input logic app);
    logic [11:0] e;
    e = app ? expOf(raw, ch) : raw;
    @(posedge sys_clk);
    resultValid <= 1'b1;
    resultRaw <= raw;
    resultChannel <= ch;
    resultPrescaler <= pre;
    resultSaturated <= sat;
    @(posedge sys_clk);
    resultValid <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    chk(outValid === 1'b0, "output too early");
    @(posedge sys_clk);
    #1;
    chk(outValid === 1'b1 && outResult === e && outCorrected === app, "result");
    chk(outChannel === ch && outPrescaler === pre && outSaturated === sat, "tag");
  endtask

  task automatic testLoad();
    int n;
    send(12'h100, 5'h01, 3'h2, 1'b0, 1'b0);
    n = 0;
    while (initDone !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk(initDone === 1'b1, "load never finished");
    chk(lutCnt == 30, "lookup writes");
    chk(coefCnt == 240, "coefficient writes");
    chk(addrBad == 0, "flash address or enable overlap");
    regCheck(CTRL_OFS, 32'h1);
    regCheck(STATUS_OFS, 32'h1);
    $display("test load done");
  endtask

  task automatic testCorrect();
    send(12'h100, 5'h01, 3'h2, 1'b0, 1'b1);
    send(12'hFFF, 5'h02, 3'h7, 1'b0, 1'b1);
    send(12'h004, 5'h01, 3'h0, 1'b0, 1'b1);
    send(12'h200, 5'h1D, 3'h7, 1'b0, 1'b1);
    send(12'h123, 5'h00, 3'h5, 1'b0, 1'b1);
    send(12'h321, 5'h03, 3'h1, 1'b0, 1'b0);
    send(12'h321, 5'h1E, 3'h1, 1'b0, 1'b0);
    $display("test correct done");
  endtask

  task automatic testRefSat();
    regWrite(CTRL_OFS, 32'h0);
    send(12'h400, 5'h01, 3'h3, 1'b0, 1'b0);
    regWrite(CTRL_OFS, 32'h1);
    send(12'hFFF, 5'h04, 3'h3, 1'b1, 1'b1);
    regWrite(CTRL_OFS, 32'h3);
    send(12'hFFF, 5'h04, 3'h3, 1'b1, 1'b0);
    send(12'h080, 5'h04, 3'h3, 1'b0, 1'b1);
    regWrite(CTRL_OFS, 32'h1);
    $display("test reference and saturation done");
  endtask

  task automatic testRegs();
    regCheck(8'h08, 32'h0);
    regWrite(8'h08, 32'hFFFFFFFF);
    regCheck(CTRL_OFS, 32'h1);
    regWrite(CTRL_OFS, 32'h2);
    regCheck(CTRL_OFS, 32'h2);
    regWrite(CTRL_OFS, 32'h1);
    $display("test registers done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    testLoad();
    testCorrect();
    testRefSat();
    testRegs();
    finish_test();
  end

  // whole run is well under 1000 cycles
  initial begin
    #(40 * 3000);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
